// ===== rtl/link_state_defs.svh
// Purpose: Constants for the serial slave link-state controller
// Assumes: core_clk at 100 MHz
// Notes:   Times in ns; cycle counts derived from them
`ifndef LINK_STATE_DEFS_SVH
`define LINK_STATE_DEFS_SVH
`define CLK_PERIOD_NS        10
`define REQ_PULSE_NS         100000
`define REQ_PULSE_CYC        ((`REQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SEL_DELAY_NS         1000
`define SEL_DELAY_CYC        ((`SEL_DELAY_NS) / `CLK_PERIOD_NS)
`define FRAME_BITS           16
`define READY_FRAME_RST      16'h5aa5
`endif

// ===== rtl/link_state_pkg.sv
// Purpose: Types for the serial slave link-state controller
// Assumes: Nothing
// Notes:   One-hot state codes
package link_state_pkg;
  typedef enum logic [4:0] {
    ST_INITIAL  = 5'h01,
    ST_DESEL    = 5'h02,
    ST_PROACT   = 5'h04,
    ST_SELECTED = 5'h08,
    ST_WAITSEL  = 5'h10
  } link_state_type;
endpackage : link_state_pkg

// ===== rtl/spi_slave_link_state_control.sv
// Purpose: Link-state control of a serial peripheral slave, 4 or 5 signal variant
// Assumes: Serial clock mode 0, pins sampled by core_clk through two flops
// Notes:   Reset command comes as a level from the link layer above
`timescale 1ns/1ps
`default_nettype none
`include "link_state_defs.svh"
module spi_slave_link_state_control (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        five_signal_mode,
  input  wire logic        soft_reset,
  input  wire logic        reset_ack_sent,
  input  wire logic        ready_frame_pending,
  input  wire logic [15:0] ready_frame_data,
  input  wire logic        sclk_pin,
  input  wire logic        mosi_pin,
  input  wire logic        select_n_in,
  output logic             select_n_out,
  output logic             select_n_oe_n,
  output logic             attention_out,
  output logic             miso_out,
  output logic             miso_oe_n,
  output logic             param_frame_valid,
  output logic [15:0]      param_frame_data,
  output logic             selected_flag,
  output logic             ready_frame_done
);
  link_state_pkg::link_state_type state_q, state_d;
  logic [2:0]  sclk_s_q, sel_s_q;
  logic [1:0]  mosi_s_q;
  logic [16:0] timer_q;
  logic [4:0]  bit_cnt_q;
  logic [15:0] rx_shift_q, tx_shift_q;
  logic        got_param_q, sending_q;
  logic        sclk_rise, sclk_fall, sel_low, sel_fell, sel_rose;

  // Sync stage 0 read only by stage 1; edges on stages 1 and 2
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_s_q <= 3'h0;
      sel_s_q  <= 3'h7;
      mosi_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_pin};
      sel_s_q  <= {sel_s_q[1:0], select_n_in};
      mosi_s_q <= {mosi_s_q[0], mosi_pin};
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  assign sel_low   = ~sel_s_q[1];
  assign sel_fell  = ~sel_s_q[1] & sel_s_q[2];
  assign sel_rose  = sel_s_q[1] & ~sel_s_q[2];

  // In four-signal mode own request pulls select low; that edge is not a master select
  always_comb begin
    state_d = state_q;
    case (state_q)
      link_state_pkg::ST_INITIAL: begin
        if (got_param_q && sel_rose && !soft_reset) begin
          state_d = link_state_pkg::ST_DESEL;
        end
      end
      link_state_pkg::ST_DESEL: begin
        if (soft_reset) begin
          state_d = link_state_pkg::ST_INITIAL;
        end else if (sel_fell) begin
          state_d = link_state_pkg::ST_SELECTED;
        end else if (ready_frame_pending && !selected_flag) begin
          state_d = link_state_pkg::ST_PROACT;
        end
      end
      link_state_pkg::ST_PROACT: begin
        if (soft_reset) begin
          state_d = link_state_pkg::ST_INITIAL;
        end else if (timer_q == 17'(`REQ_PULSE_CYC - 1)) begin
          state_d = link_state_pkg::ST_WAITSEL;
        end
      end
      link_state_pkg::ST_WAITSEL: begin
        if (soft_reset) begin
          state_d = link_state_pkg::ST_INITIAL;
        end else if (timer_q < 17'd4) begin
          state_d = link_state_pkg::ST_WAITSEL; // Let released line settle through sync
        end else if (sel_low) begin
          state_d = link_state_pkg::ST_SELECTED;
        end
      end
      link_state_pkg::ST_SELECTED: begin
        if (soft_reset) begin
          state_d = link_state_pkg::ST_INITIAL;
        end else if (sel_rose) begin
          state_d = link_state_pkg::ST_DESEL;
        end
      end
      default: state_d = link_state_pkg::ST_INITIAL;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= link_state_pkg::ST_INITIAL;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      timer_q <= 17'h0;
    end else if (state_d != state_q) begin
      timer_q <= 17'h0;
    end else if (timer_q != 17'h1ffff) begin
      timer_q <= timer_q + 17'h1;
    end
  end

  // Decodes shared by several output flops
  function automatic logic requesting(
    input link_state_pkg::link_state_type s
  );
    return s == link_state_pkg::ST_PROACT;
  endfunction : requesting

  function automatic logic drives_miso(
    input link_state_pkg::link_state_type s
  );
    return s == link_state_pkg::ST_SELECTED;
  endfunction : drives_miso

  function automatic logic frame_starts(
    input link_state_pkg::link_state_type cur,
    input link_state_pkg::link_state_type nxt
  );
    return cur == link_state_pkg::ST_WAITSEL && nxt == link_state_pkg::ST_SELECTED;
  endfunction : frame_starts

  logic [4:0]  tx_cnt_q;
  logic [15:0] rx_word;
  logic        rx_take, rx_last, tx_start, tx_shift_en, tx_last;

  assign rx_take     = sel_low && sclk_rise && !soft_reset && state_q == link_state_pkg::ST_INITIAL;
  assign rx_last     = rx_take && bit_cnt_q == 5'(`FRAME_BITS - 1);
  assign rx_word     = {rx_shift_q[14:0], mosi_s_q[1]};
  assign tx_start    = frame_starts(state_q, state_d);
  assign tx_shift_en = sending_q && sclk_fall && drives_miso(state_d) && !tx_start;
  // Counting falls, not looking at data, so frames ending in zeros still end
  assign tx_last     = tx_shift_en && tx_cnt_q == 5'(`FRAME_BITS - 1);

  // Select is only ever driven low, so a master pulling it low never fights it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      select_n_out <= 1'b1;
    end else begin
      select_n_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      select_n_oe_n <= 1'b1;
    end else begin
      select_n_oe_n <= !(requesting(state_d) && !five_signal_mode);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      attention_out <= 1'b0;
    end else begin
      attention_out <= requesting(state_d) && five_signal_mode;
    end
  end

  // Receive path in initial state: parameter request frame
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= 5'h0;
    end else if (soft_reset || !sel_low) begin
      bit_cnt_q <= 5'h0;
    end else if (rx_last) begin
      bit_cnt_q <= 5'h0;
    end else if (rx_take) begin
      bit_cnt_q <= bit_cnt_q + 5'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_shift_q <= 16'h0;
    end else if (rx_take) begin
      rx_shift_q <= rx_word;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      got_param_q <= 1'b0;
    end else if (soft_reset) begin
      got_param_q <= 1'b0;
    end else if (rx_last) begin
      got_param_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      param_frame_valid <= 1'b0;
    end else begin
      param_frame_valid <= rx_last;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      param_frame_data <= 16'h0;
    end else if (rx_last) begin
      param_frame_data <= rx_word;
    end
  end

  // Transmit path; slow clock leaves ample margin for sync latency
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      selected_flag <= 1'b0;
    end else begin
      selected_flag <= drives_miso(state_d);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= !drives_miso(state_d);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_shift_q <= `READY_FRAME_RST;
    end else if (tx_start) begin
      tx_shift_q <= ready_frame_data;
    end else if (tx_shift_en) begin
      tx_shift_q <= {tx_shift_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      miso_out <= 1'b0;
    end else if (tx_start) begin
      miso_out <= ready_frame_data[15];
    end else if (tx_shift_en) begin
      miso_out <= tx_shift_q[14];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_cnt_q <= 5'h0;
    end else if (tx_start) begin
      tx_cnt_q <= 5'h0;
    end else if (tx_shift_en) begin
      tx_cnt_q <= tx_cnt_q + 5'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sending_q <= 1'b0;
    end else if (tx_start) begin
      sending_q <= 1'b1;
    end else if (!drives_miso(state_d) || tx_last) begin
      sending_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ready_frame_done <= 1'b0;
    end else begin
      ready_frame_done <= tx_last;
    end
  end
endmodule : spi_slave_link_state_control
`default_nettype wire

// ===== tb/spi_slave_link_state_control_assertions.sv
// Purpose: Link-state checker
// Assumes: Mode 0 pins; Notes: bound to the top
`timescale 1ns/1ps
`default_nettype none
`include "link_state_defs.svh"
module link_state_checker (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic five_signal_mode,
  input wire logic soft_reset,
  input wire logic select_n_in,
  input wire logic select_n_out,
  input wire logic select_n_oe_n,
  input wire logic attention_out,
  input wire logic miso_oe_n,
  input wire logic selected_flag
);
  localparam logic [16:0] REQ_CYC = 17'(`REQ_PULSE_CYC);
  logic        req;
  logic [16:0] cnt_q;
  assign req = attention_out | ~select_n_oe_n;
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst) cnt_q <= 17'h0;
    else cnt_q <= req ? cnt_q + 17'h1 : 17'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Eight cycles covers the two sync flops plus state update
  sequence line_idle; select_n_in[*8]; endsequence
  miso_hiz_a: assert property (!miso_oe_n |-> selected_flag || $past(selected_flag)) else $error("miso driven");
  idle_quiet_a: assert property (line_idle |-> !selected_flag && miso_oe_n) else $error("active idle");
  req_pin_a: assert property (req |-> {attention_out, select_n_oe_n} == {2{five_signal_mode}}) else $error("bad pin");
  drive_low_a: assert property (!select_n_oe_n |-> !select_n_out) else $error("select high");
  pulse_len_a: assert property ($fell(req) |-> cnt_q == REQ_CYC) else $error("bad pulse");
  proact_quiet_a: assert property (req |-> miso_oe_n && !selected_flag) else $error("busy in request");
  desel_hiz_a: assert property ($rose(select_n_in) |-> ##[1:6] miso_oe_n) else $error("miso kept");
  reset_quiet_a: assert property (soft_reset[*2] |-> !req && miso_oe_n) else $error("reset noise");
endmodule : link_state_checker
bind spi_slave_link_state_control link_state_checker chk (.*);
`default_nettype wire

// ===== tb/spi_host_model.sv
// Purpose: Bus master model
// Assumes: Mode 0, 125 ns bit; Notes: select is open drain
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic      sclk,
  output logic      mosi,
  output logic      sel_drv_n,
  input  wire logic miso
);
  initial begin
    sclk = 1'h0;
    mosi = 1'h0;
    sel_drv_n = 1'h1;
  end
  // Clock stands low outside frames; mosi flips so stale data never persists
  task automatic xfer(input logic sel, input logic [15:0] tx, output logic [15:0] rx);
    sel_drv_n = ~sel;
    #1000;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #62.5 sclk = 1'h1;
      rx[i] = miso;
      #62.5 sclk = 1'h0;
    end
    #500 sel_drv_n = 1'h1;
    mosi = ~mosi;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ===== tb/spi_slave_link_state_control_test.sv
// Purpose: Link-state bench
// Assumes: Mode 0; Notes: host model on far side
`timescale 1ns/1ps
`default_nettype none
`include "link_state_defs.svh"
module spi_slave_link_state_control_test;
  logic core_clk = 1'h0, nrst = 1'h0, five_signal_mode = 1'h0, soft_reset = 1'h0, reset_ack_sent = 1'h0;
  logic ready_frame_pending = 1'h0, sclk_pin, mosi_pin, sel_drv_n, select_n_in, miso_w, select_n_out;
  logic select_n_oe_n, attention_out, miso_out, miso_oe_n, param_frame_valid, selected_flag, ready_frame_done;
  logic [15:0] ready_frame_data = 16'h0, param_frame_data, rx, junk;
  int n_errors = 0, compares = 0, n_param = 0, n_done = 0;
  spi_slave_link_state_control dut (.*);
  spi_host_model host (.sclk(sclk_pin), .mosi(mosi_pin), .sel_drv_n(sel_drv_n), .miso(miso_w));
  assign select_n_in = sel_drv_n & (select_n_oe_n | select_n_out);
  assign miso_w = miso_oe_n ? core_clk : miso_out; // Released line toggles
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) n_param += int'(param_frame_valid === 1'h1);
  always @(posedge core_clk) n_done += int'(ready_frame_done === 1'h1);
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic t_cfg(input logic mode, input logic [15:0] frame);
    int np;
    @(negedge core_clk);
    five_signal_mode = mode;
    host.xfer(1'h1, frame, rx);
    np = n_param;
    host.xfer(1'h0, ~frame, junk);
    @(negedge core_clk);
    chk({param_frame_data, miso_oe_n}, {frame, 1'h1});
    chk(17'(n_param - np), 17'h0);
  endtask : t_cfg
  task automatic t_req(input logic [15:0] data);
    logic [16:0] n;
    int nd;
    n = 17'h0;
    ready_frame_data = data;
    ready_frame_pending = 1'h1;
    for (int i = 0; i < 8 && attention_out !== 1'h1 && select_n_oe_n !== 1'h0; i++) @(negedge core_clk);
    fork host.xfer(1'h0, 16'h0f0f, junk); join_none
    while ((attention_out === 1'h1 || select_n_oe_n === 1'h0) && n < 17'h1ffff) begin
      @(negedge core_clk);
      n++;
    end
    ready_frame_pending = 1'h0;
    chk(n, 17'(`REQ_PULSE_CYC));
    repeat (20) @(negedge core_clk);
    chk({15'h0, selected_flag, miso_oe_n}, 17'h1);
    nd = n_done;
    host.xfer(1'h1, 16'h0, rx);
    chk({1'h0, rx}, {1'h0, data});
    chk(17'(n_done - nd), 17'h1);
    repeat (8) @(negedge core_clk);
    chk({15'h0, selected_flag, miso_oe_n}, 17'h1);
  endtask : t_req
  task automatic t_rst;
    soft_reset = 1'h1;
    @(negedge core_clk);
    ready_frame_pending = 1'h1;
    repeat (4) @(negedge core_clk);
    soft_reset = 1'h0;
    repeat (300) @(negedge core_clk);
    chk({14'h0, attention_out, select_n_oe_n, miso_oe_n}, 17'h3);
    reset_ack_sent = 1'h1;
    ready_frame_pending = 1'h0;
  endtask : t_rst
  initial begin
    repeat (20) @(negedge core_clk);
    nrst = 1'h1;
    for (int m = 0; m < 2; m++) begin
      t_cfg(m[0], m[0] ? 16'hc3fe : 16'h3c01);
      t_req(m[0] ? 16'h8001 : 16'h7ffe);
      t_rst();
    end
    finish_test();
  end
  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end
endmodule : spi_slave_link_state_control_test
`default_nettype wire
